/* common/ssc_pkg.sv */
package ssc_pkg;
  // register byte offsets
  localparam logic [11:0] SSC_CTRL_OFS    = 12'h000;
  localparam logic [11:0] SSC_KEYPAD_OFS  = 12'h004;
  localparam logic [11:0] SSC_COMM_OFS    = 12'h008;
  localparam logic [11:0] SSC_REF_OFS     = 12'h00c;
  localparam logic [11:0] SSC_AIN1_MON    = 12'h010;
  localparam logic [11:0] SSC_AIN2_MON    = 12'h014;
  localparam logic [11:0] SSC_ASPD_MON    = 12'h018;
  localparam logic [11:0] SSC_CH1_BASE    = 12'h020;
  localparam logic [11:0] SSC_CH2_BASE    = 12'h040;
  localparam logic [11:0] SSC_MS_SPD_BASE = 12'h100;
  localparam logic [11:0] SSC_MS_TIM_BASE = 12'h140;
  // per-channel word index inside a channel block
  localparam logic [2:0]  SSC_CH_FTIME    = 3'h0;
  localparam logic [2:0]  SSC_CH_DRIFT    = 3'h1;
  localparam logic [2:0]  SSC_CH_OFFSET   = 3'h2;
  localparam logic [2:0]  SSC_CH_DEAD     = 3'h3;
  localparam logic [2:0]  SSC_CH_FSCALE   = 3'h4;
  // control field positions
  localparam int          SSC_SRC_LSB     = 0;
  localparam int          SSC_MAIN_LSB    = 4;
  localparam int          SSC_AUX_LSB     = 8;
  localparam int          SSC_ABSEL_BIT   = 12;
  localparam int          SSC_ADJ_BIT     = 16;
  localparam int          SSC_ACC_LSB     = 16;
  // source codes
  localparam logic [2:0]  SSC_SRC_A       = 3'h0;
  localparam logic [2:0]  SSC_SRC_B       = 3'h1;
  localparam logic [2:0]  SSC_SRC_SUM     = 3'h2;
  localparam logic [2:0]  SSC_SRC_SWITCH  = 3'h3;
  localparam logic [2:0]  SSC_SRC_COMM    = 3'h4;
  localparam logic [2:0]  SSC_REF_DIGITAL = 3'h0;
  localparam logic [2:0]  SSC_REF_AIN1    = 3'h1;
  localparam logic [2:0]  SSC_REF_AIN2    = 3'h2;
  localparam logic [2:0]  SSC_AUX_MULTI   = 3'h5;
  // reset values and limits
  localparam logic [15:0] SSC_KEYPAD_RST  = 16'h00c8;
  localparam logic [15:0] SSC_FTIME_RST   = 16'h00c8;
  localparam logic [15:0] SSC_FSCALE_RST  = 16'h0bb8;
  localparam logic [2:0]  SSC_AUX_RST     = 3'h1;
  localparam int          SSC_SPEED_LIM   = 6000;
  localparam int          SSC_OFFSET_LIM  = 5000;
  localparam int          SSC_FULL_MV     = 10000;
  // filter timing: constant counted in 0.01 ms, samples every SSC_SAMPLE_NS
  localparam int          SSC_FT_UNIT_NS  = 10000;
  localparam int          SSC_SAMPLE_NS   = 50000;
  localparam int          SSC_HIST        = 16;

  // whole state of the block, registered as one word
  typedef struct packed {
    logic [2:0]              src_q;
    logic [2:0]              main_q;
    logic [2:0]              aux_q;
    logic                    ab_sel_q;
    logic [15:0]             keypad_q;
    logic [15:0]             comm_q;
    logic [1:0][15:0]        ftime_q;
    logic [1:0][15:0]        drift_q;
    logic [1:0][15:0]        offset_q;
    logic [1:0][15:0]        dead_q;
    logic [1:0][15:0]        fscale_q;
    logic [15:0][15:0]       ms_spd_q;
    logic [15:0][15:0]       ms_tim_q;
    logic [15:0][1:0]        ms_acc_q;
    logic [1:0][15:0][15:0]  hist_q;
    logic [1:0][15:0]        filt_q;
    logic [1:0][15:0]        aref_q;
    logic [15:0]             ref_q;
    logic [15:0]             ms_tim_out_q;
    logic [1:0]              ms_acc_out_q;
    logic                    pready_q;
    logic                    pslverr_q;
    logic [31:0]             prdata_q;
  } ssc_state_t;

  // power-on values of the state word
  function automatic ssc_state_t ssc_rst_val();
    ssc_state_t s;
    s = '0;
    s.aux_q    = SSC_AUX_RST;
    s.keypad_q = SSC_KEYPAD_RST;
    s.ftime_q  = {SSC_FTIME_RST, SSC_FTIME_RST};
    s.fscale_q = {SSC_FSCALE_RST, SSC_FSCALE_RST};
    return s;
  endfunction
endpackage

/* logic/ssc_speed_ref.sv */
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ns
module ssc_speed_ref
  import ssc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // apb slave
  input  wire logic [11:0] paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // analog samples in millivolts, signed
  input  wire logic [15:0] analog_in_one_in,
  input  wire logic [15:0] analog_in_two_in,
  input  wire logic        sample_valid_in,
  // drive status and multi-speed step from the sequencer
  input  wire logic        motor_running_in,
  input  wire logic [3:0]  ms_index_in,
  // conditioned speed reference and current step settings
  output logic      [15:0] speed_ref_out,
  output logic      [15:0] ms_run_time_out,
  output logic      [1:0]  ms_accel_set_out
);
  import ssc_pkg::*;

  // the whole block is one state word: settings, sample history,
  // conditioned values and the bus answer all move on the same edge.
  // keeping them together makes the reset image a single constant and
  // lets the next-state process start from a copy of the present word.
  // ref_a and ref_b below are scratch values of that process only.
  ssc_state_t q;                        // registered state
  ssc_state_t d;                        // next state
  logic       wr_commit;                // write takes effect this edge
  logic       rd_go;                    // answer is prepared this cycle
  logic [31:0] rdata;                   // read mux result
  logic       hit;                      // address is mapped
  logic [1:0] ch_sel;                   // which channel block is addressed
  logic [2:0] ch_word;                  // word within channel block
  logic [15:0] ref_a;                   // main reference a
  logic [15:0] ref_b;                   // auxiliary reference b

  // helper functions: clamp16, sat16 and pick are each used by more than one path, so the
  // arithmetic is written once and every caller sees the same rounding.
  // clamp a signed value to +-lim, keeps written keypad and offset values in range
  function automatic logic [15:0] clamp16(input logic [31:0] v, input int lim);
    logic signed [31:0] sv;
    sv = $signed(v);
    if (sv > lim)
      return 16'(lim);
    else if (sv < -lim)
      return 16'(-lim);
    return v[15:0];
  endfunction

  // results beyond the speed range are pinned at the limit instead of
  // wrapping, which would flip the direction of rotation.
  // saturate a wide signed value into the 16-bit speed range
  function automatic logic [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sh7fff)
      return 16'h7fff;
    else if (v < -48'sh8000)
      return 16'h8000;
    return v[15:0];
  endfunction

  // the filter time is counted in steps of 0.01 ms.
  // a small constant gives a window of one, i.e. no averaging at all.
  // window length as a power of two from the filter time constant
  function automatic logic [2:0] win_shift(input logic [15:0] ft);
    logic [31:0] n;
    n = (32'(ft) * 32'(SSC_FT_UNIT_NS)) / 32'(SSC_SAMPLE_NS);
    if (n >= 32'h10)
      return 3'h4;
    else if (n >= 32'h8)
      return 3'h3;
    else if (n >= 32'h4)
      return 3'h2;
    else if (n >= 32'h2)
      return 3'h1;
    return 3'h0;
  endfunction

  // the true window would be the time constant over the sample period;
  // a power-of-two length trades some accuracy of the corner frequency
  // for a shift instead of a divider, and sixteen entries bound the area.
  // a time constant longer than sixteen periods still averages sixteen.
  // moving average over the newest 2^sh samples; zero time passes raw
  function automatic logic [15:0] mavg(input logic [15:0][15:0] h, input logic [15:0] ft);
    logic signed [20:0] acc;
    logic [2:0]         sh;
    acc = '0;
    sh  = win_shift(ft);
    if (ft == 16'h0)
      return h[0];
    for (int i = 0; i < SSC_HIST; i++)
    begin
      if (i < (1 << sh))
        acc = acc + 21'($signed(h[i]));
    end
    // the arithmetic shift divides by the window length, rounding down.
    acc = acc >>> sh;
    return acc[15:0];
  endfunction

  // stages follow the analog path in order: drift, offset, dead band,
  // scaling. all of it is 48 bits wide so no stage can wrap before the
  // final saturation; the product of a full-range sample and a large
  // full-scale speed needs more than 32 bits.
  // the dead band is centred on the offset, since the offset has
  // already been removed when the band is tested.
  // drift, offset, dead zone and full-scale scaling of one channel
  function automatic logic [15:0] cond(input logic [15:0] filt, input logic [15:0] drift,
                                       input logic [15:0] ofs, input logic [15:0] dz,
                                       input logic [15:0] fs);
    logic signed [47:0] y3;
    logic signed [47:0] y4;
    logic signed [47:0] y5;
    logic signed [47:0] y6;
    logic signed [47:0] dzw;
    y3  = 48'($signed(filt)) - 48'($signed(drift));
    y4  = y3 - 48'($signed(ofs));
    dzw = 48'(dz);
    // the band edges themselves count as inside the band.
    if ((y4 <= dzw) && (y4 >= -dzw))
      y5 = '0;
    else
      y5 = y4;
    y6 = (y5 * 48'($signed(fs))) / 48'(SSC_FULL_MV);
    return sat16(y6);
  endfunction

  // unused codes give zero, which stops the motor rather than letting
  // a stale or undefined source run it.
  // select one reference source by its code
  function automatic logic [15:0] pick(input logic [2:0] code, input ssc_state_t s,
                                       input logic [3:0] idx);
    case (code)
      SSC_REF_DIGITAL: return s.keypad_q;
      SSC_REF_AIN1:    return s.aref_q[0];
      SSC_REF_AIN2:    return s.aref_q[1];
      SSC_AUX_MULTI:   return s.ms_spd_q[idx];
      default:         return 16'h0;
    endcase
  endfunction

  // register map in brief: control and plain values sit in the low
  // words, the two channel blocks follow at 0x20 and 0x40, and the
  // multi-speed table takes two runs of sixteen words higher up.
  // address decode helpers
  always_comb
  begin
    ch_sel  = 2'h0;
    ch_word = paddr_in[4:2];
    if (paddr_in[11:5] == SSC_CH1_BASE[11:5])
      ch_sel = 2'h1;
    else if (paddr_in[11:5] == SSC_CH2_BASE[11:5])
      ch_sel = 2'h2;
  end

  // the read mux looks only at the registered state, so a read never
  // sees a half-updated value from the cycle in which a write lands.
  // read mux; unmapped addresses read zero and answer with an error
  always_comb
  begin
    rdata = '0;
    hit   = 1'b1;
    if (ch_sel != 2'h0)
    begin
      case (ch_word)
        SSC_CH_FTIME:  rdata = {16'h0, q.ftime_q[ch_sel - 2'h1]};
        SSC_CH_DRIFT:  rdata = {{16{q.drift_q[ch_sel - 2'h1][15]}}, q.drift_q[ch_sel - 2'h1]};
        SSC_CH_OFFSET: rdata = {{16{q.offset_q[ch_sel - 2'h1][15]}}, q.offset_q[ch_sel - 2'h1]};
        SSC_CH_DEAD:   rdata = {16'h0, q.dead_q[ch_sel - 2'h1]};
        SSC_CH_FSCALE: rdata = {16'h0, q.fscale_q[ch_sel - 2'h1]};
        default:       hit = 1'b0;
      endcase
    end
    // table words: speed and ramp set share one word, run time another
    else if (paddr_in[11:6] == SSC_MS_SPD_BASE[11:6])
      rdata = {14'h0, q.ms_acc_q[paddr_in[5:2]], q.ms_spd_q[paddr_in[5:2]]};
    else if (paddr_in[11:6] == SSC_MS_TIM_BASE[11:6])
      rdata = {16'h0, q.ms_tim_q[paddr_in[5:2]]};
    else
    begin
      case ({paddr_in[11:2], 2'b00})
        SSC_CTRL_OFS:   rdata = {19'h0, q.ab_sel_q, 1'b0, q.aux_q, 1'b0, q.main_q, 1'b0, q.src_q};
        SSC_KEYPAD_OFS: rdata = {{16{q.keypad_q[15]}}, q.keypad_q};
        SSC_COMM_OFS:   rdata = {{16{q.comm_q[15]}}, q.comm_q};
        SSC_REF_OFS:    rdata = {{16{q.ref_q[15]}}, q.ref_q};
        SSC_AIN1_MON:   rdata = {{16{q.filt_q[0][15]}}, q.filt_q[0]};
        SSC_AIN2_MON:   rdata = {{16{q.filt_q[1][15]}}, q.filt_q[1]};
        SSC_ASPD_MON:   rdata = (q.main_q == SSC_REF_AIN1)
                                ? {{16{q.aref_q[0][15]}}, q.aref_q[0]}
                                : {{16{q.aref_q[1][15]}}, q.aref_q[1]};
        default:        hit = 1'b0;
      endcase
    end
  end

  // the bus answers after exactly one wait state: the first access cycle
  // prepares read data, the second shows pready. a write is held back to
  // that second edge so it lands where the master samples pready.
  // samples arrive as a stream with no back-pressure; a strobe in a
  // cycle with a bus write is still taken, the two touch no common field
  // except through auto adjust, which reads the previous filtered value.
  // next-state logic: bus, sample stream and reference selection
  always_comb
  begin
    d         = q;
    rd_go     = psel_in && penable_in && !q.pready_q;
    wr_commit = psel_in && penable_in && q.pready_q && pwrite_in && hit;
    // one wait state, then pready for a single cycle
    d.pready_q  = rd_go;
    d.pslverr_q = rd_go && !hit;
    if (rd_go)
      d.prdata_q = pwrite_in ? 32'h0 : rdata;
    // an unmapped write still gets its answer; it is simply dropped.
    // register writes land only at the edge where pready is sampled
    if (wr_commit)
    begin
      if (ch_sel != 2'h0)
      begin
        case (ch_word)
          SSC_CH_FTIME:  d.ftime_q[ch_sel - 2'h1]  = pwdata_in[15:0];
          SSC_CH_DRIFT:  d.drift_q[ch_sel - 2'h1]  = pwdata_in[15:0];
          SSC_CH_OFFSET: d.offset_q[ch_sel - 2'h1] = clamp16(pwdata_in, SSC_OFFSET_LIM);
          SSC_CH_DEAD:   d.dead_q[ch_sel - 2'h1]   = pwdata_in[15:0];
          SSC_CH_FSCALE: d.fscale_q[ch_sel - 2'h1] = pwdata_in[15:0];
          default:       d.dead_q = q.dead_q;
        endcase
      end
      else if (paddr_in[11:6] == SSC_MS_SPD_BASE[11:6])
      begin
        d.ms_spd_q[paddr_in[5:2]] = pwdata_in[15:0];
        d.ms_acc_q[paddr_in[5:2]] = pwdata_in[SSC_ACC_LSB +: 2];
      end
      else if (paddr_in[11:6] == SSC_MS_TIM_BASE[11:6])
        d.ms_tim_q[paddr_in[5:2]] = pwdata_in[15:0];
      else
      begin
        case ({paddr_in[11:2], 2'b00})
          SSC_CTRL_OFS:
          begin
            d.ab_sel_q = pwdata_in[SSC_ABSEL_BIT];
            // source, main and aux selections are frozen while the motor turns, the a/b switch bit is not; bad codes are dropped
            if (!motor_running_in)
            begin
              if (pwdata_in[SSC_SRC_LSB +: 3] <= SSC_SRC_COMM)
                d.src_q = pwdata_in[SSC_SRC_LSB +: 3];
              if (pwdata_in[SSC_MAIN_LSB +: 3] <= SSC_REF_AIN2)
                d.main_q = pwdata_in[SSC_MAIN_LSB +: 3];
              if (pwdata_in[SSC_AUX_LSB +: 3] <= SSC_AUX_MULTI)
                d.aux_q = pwdata_in[SSC_AUX_LSB +: 3];
            end
            // the adjust bit is a strobe: it reads back as zero and is not
            // stored, so writing the control word again does not re-trim.
            // auto adjust: take present filtered samples as zero drift
            if (pwdata_in[SSC_ADJ_BIT])
              d.drift_q = q.filt_q;
          end
          SSC_KEYPAD_OFS: d.keypad_q = clamp16(pwdata_in, SSC_SPEED_LIM);
          SSC_COMM_OFS:   d.comm_q   = pwdata_in[15:0];
          default:        d.comm_q   = q.comm_q;
        endcase
      end
    end
    // the newest sample enters index zero and the oldest falls off the end;
    // with the filter off the newest entry is used as it stands.
    // shift new samples into the averaging history
    if (sample_valid_in)
    begin
      d.hist_q[0] = {q.hist_q[0][14:0], analog_in_one_in};
      d.hist_q[1] = {q.hist_q[1][14:0], analog_in_two_in};
    end
    // both channels are conditioned alike; only their settings differ.
    // the drift and offset inputs are taken from registers, so a change
    // written over the bus shows at the output within three edges.
    // conditioning runs every cycle so setting changes act at once
    for (int c = 0; c < 2; c++)
    begin
      d.filt_q[c] = mavg(q.hist_q[c], q.ftime_q[c]);
      d.aref_q[c] = cond(q.filt_q[c], q.drift_q[c], q.offset_q[c],
                         q.dead_q[c], q.fscale_q[c]);
      // both candidate references are formed every cycle; the source code
      // only chooses among them, so a switch takes effect on the next edge.
      // switchover is steered by the control bit, as the external switch
      // input is not part of this block.
      // the sum saturates so that two large references of one sign cannot
      // wrap into a large reference of the other sign.
    end
    ref_a = pick(q.main_q, q, ms_index_in);
    ref_b = pick(q.aux_q, q, ms_index_in);
    case (q.src_q)
      SSC_SRC_A:      d.ref_q = ref_a;
      SSC_SRC_B:      d.ref_q = ref_b;
      SSC_SRC_SUM:    d.ref_q = sat16(48'($signed(ref_a)) + 48'($signed(ref_b)));
      SSC_SRC_SWITCH: d.ref_q = q.ab_sel_q ? ref_b : ref_a;
      SSC_SRC_COMM:   d.ref_q = q.comm_q;
      default:        d.ref_q = ref_a;
    endcase
    // the table entry for the running step is registered like the other
    // outputs, which delays it by one edge against the step index.
    d.ms_tim_out_q = q.ms_tim_q[ms_index_in];
    d.ms_acc_out_q = q.ms_acc_q[ms_index_in];
  end

  // a sample reaches the reference output three edges after it is taken:
  // filtered value, conditioned value and then the selected reference.
  // state register; reset loads the power-on constants
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      q <= ssc_rst_val();
    else
      q <= d;
  end

  // no output is formed by logic after the register, so every output
  // changes only on a clock edge and cannot glitch.
  // outputs straight from flip-flops
  assign prdata_out       = q.prdata_q;
  assign pready_out       = q.pready_q;
  assign pslverr_out      = q.pslverr_q;
  assign speed_ref_out    = q.ref_q;
  assign ms_run_time_out  = q.ms_tim_out_q;
  assign ms_accel_set_out = q.ms_acc_out_q;
endmodule

/* tb/ssc_speed_ref_sva.sv */
`timescale 1ns/1ns
// watches the bus handshake and the quiet-time stability of the reference
module ssc_speed_ref_sva (
  // clock, reset, bus request and sample strobe
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [11:0] paddr_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic        sample_valid_in,
  // answers of the block
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [15:0] speed_ref_out
);
  logic [2:0] quiet_q; // cycles with no sample and no bus answer
  // saturating count: the output may move for a few edges after a cause
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      quiet_q <= 3'h0;
    else if (sample_valid_in || pready_out)
      quiet_q <= 3'h0;
    else if (quiet_q != 3'h7)
      quiet_q <= quiet_q + 3'h1;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // setup phase, then one wait state, then the answer
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_answer;
    !pready_out ##1 pready_out;
  endsequence
  a_one_wait: assert property (s_setup |=> s_answer)
    else $error("answer not after one wait state");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready outside an access");
  a_idle_quiet: assert property (!psel_in |=> !pready_out)
    else $error("ready without a request");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_err_data: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
    else $error("refused read returned data");
  a_mapped_ok: assert property (pready_out && paddr_in < 12'h01c
    && paddr_in[1:0] == 2'h0 |-> !pslverr_out)
    else $error("mapped address refused");
  a_ref_quiet: assert property (quiet_q == 3'h7 |-> $stable(speed_ref_out))
    else $error("reference moved with no cause");
endmodule
bind ssc_speed_ref ssc_speed_ref_sva chk_u (.clk_in, .rst_n_in, .paddr_in,
  .psel_in, .penable_in, .pwrite_in, .sample_valid_in, .prdata_out,
  .pready_out, .pslverr_out, .speed_ref_out);

/* tb/ssc_host_model.sv */
`timescale 1ns/1ns
// host side: holds two analog levels and strobes a sample every per cycles
module ssc_host_model #(
  parameter int PER = 8
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // levels and strobe enable from the bench
  input  wire logic        run_in,
  input  wire logic [15:0] lvl_one_in,
  input  wire logic [15:0] lvl_two_in,
  // analog side of the block
  output logic      [15:0] analog_one_out,
  output logic      [15:0] analog_two_out,
  output logic             sample_valid_out
);
  logic [7:0] cnt_q; // cycles since the last strobe
  // a voltage is continuous, so the lines always carry the level
  assign analog_one_out = lvl_one_in;
  assign analog_two_out = lvl_two_in;
  // one strobe per period while enabled, never back to back unless PER is 1
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      cnt_q <= 8'h0;
      sample_valid_out <= 1'b0;
    end
    else
    begin
      cnt_q <= (run_in && cnt_q != 8'(PER - 1)) ? cnt_q + 8'h1 : 8'h0;
      sample_valid_out <= run_in && cnt_q == 8'(PER - 1);
    end
endmodule

/* tb/ssc_speed_ref_tb.sv */
`timescale 1ns/1ns
module ssc_speed_ref_tb;
  logic        clk_in, rst_n_in, psel_in, penable_in, pwrite_in;
  logic        pready_out, pslverr_out, sample_valid_in, motor_running_in;
  logic        run, rerr;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rdat;
  logic [15:0] analog_in_one_in, analog_in_two_in, speed_ref_out;
  logic [15:0] ms_run_time_out, lvl_one, lvl_two;
  logic [3:0]  ms_index_in;
  logic [1:0]  ms_accel_set_out;
  int          bad_count, n_tests;
  logic [3:0]  auxc [4] = '{4'h0, 4'h2, 4'h3, 4'h4}; // aux codes tried
  logic [15:0] auxe [4] = '{16'h0064, 16'h04b0, 16'h0000, 16'h0000};
  ssc_speed_ref dut_u (.clk_in, .rst_n_in, .paddr_in, .psel_in, .penable_in,
    .pwrite_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .analog_in_one_in, .analog_in_two_in, .sample_valid_in, .motor_running_in,
    .ms_index_in, .speed_ref_out, .ms_run_time_out, .ms_accel_set_out);
  ssc_host_model host_u (.clk_in, .rst_n_in, .run_in(run), .lvl_one_in(lvl_one),
    .lvl_two_in(lvl_two), .analog_one_out(analog_in_one_in),
    .analog_two_out(analog_in_two_in), .sample_valid_out(sample_valid_in));
  // 25 mhz clock
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // compare one value, count it, report a mismatch at once
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // one apb transfer; entered just after an edge, leaves an idle edge behind
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    paddr_in <= a;
    pwrite_in <= w;
    pwdata_in <= d;
    psel_in <= 1'b1;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 20);
    rdat = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    cmp(rdat, e);
  endtask
  // twenty edges, two and a half sample periods, cover filter, scaling and selection latency
  task automatic chk_ref(input logic [15:0] e);
    repeat (20) @(posedge clk_in);
    cmp({16'h0, speed_ref_out}, {16'h0, e});
  endtask
  // stop on the edge at which the block takes a sample
  task automatic wait_sample();
    do
      @(posedge clk_in);
    while (sample_valid_in !== 1'b1);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    conclude();
  end
  initial
  begin
    {rst_n_in, psel_in, penable_in, pwrite_in, motor_running_in, run} = '0;
    {paddr_in, pwdata_in, lvl_one, lvl_two, ms_index_in} = '0;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk_ref(16'h00c8);
    rd(12'h000, 32'h00000100);
    rd(12'h004, 32'h000000c8);
    rd(12'h020, 32'h000000c8);
    wr(12'h004, 32'hffffe4a8);
    rd(12'h004, 32'hffffe890);
    chk_ref(16'he890);
    apb(12'h0fc, 1'b0, 32'h0);
    cmp({31'h0, rerr}, 32'h1);
    cmp(rdat, 32'h0);
    wr(12'h008, 32'h000004d2);
    motor_running_in <= 1'b1;
    wr(12'h004, 32'h00000064);
    wr(12'h000, 32'h00000104);
    chk_ref(16'h0064);
    motor_running_in <= 1'b0;
    wr(12'h000, 32'h00000104);
    chk_ref(16'h04d2);
    lvl_one <= 16'h07d0;
    lvl_two <= 16'h1518;
    run <= 1'b1;
    wr(12'h040, 32'h0);
    wr(12'h044, 32'h00000190);
    wr(12'h04c, 32'h00000064);
    wr(12'h000, 32'h00000120);
    chk_ref(16'h05dc);
    rd(12'h014, 32'h00001518);
    rd(12'h018, 32'h000005dc);
    wr(12'h048, 32'h000003e8);
    chk_ref(16'h04b0);
    wr(12'h04c, 32'h00000fa0);
    chk_ref(16'h0000);
    wr(12'h04c, 32'h00000f9f);
    chk_ref(16'h04b0);
    repeat (150) @(posedge clk_in);
    rd(12'h010, 32'h000007d0);
    wait_sample();
    lvl_one <= 16'h0e10;
    wait_sample();
    rd(12'h010, 32'h00000834);
    wr(12'h000, 32'h00000121);
    repeat (150) @(posedge clk_in);
    chk_ref(16'h0438);
    for (int i = 0; i < 4; i++)
    begin
      wr(12'h000, {20'h0, auxc[i], 8'h21});
      chk_ref(auxe[i]);
    end
    wr(12'h10c, 32'h00020309);
    wr(12'h14c, 32'h00000037);
    ms_index_in <= 4'h3;
    wr(12'h000, 32'h00000521);
    chk_ref(16'h0309);
    cmp({16'h0, ms_run_time_out}, 32'h00000037);
    cmp({30'h0, ms_accel_set_out}, 32'h00000002);
    wr(12'h004, 32'h00001770);
    wr(12'h020, 32'h0);
    wr(12'h030, 32'h00007fff);
    lvl_one <= 16'h2710;
    wr(12'h000, 32'h00000102);
    chk_ref(16'h7fff);
    wr(12'h000, 32'h00000103);
    chk_ref(16'h1770);
    wr(12'h000, 32'h00001103);
    chk_ref(16'h7fff);
    wr(12'h000, 32'h00000110);
    chk_ref(16'h7fff);
    rd(12'h018, 32'h00007fff);
    wr(12'h000, 32'h00010110);
    rd(12'h024, 32'h00002710);
    rd(12'h044, 32'h00001518);
    chk_ref(16'h0000);
    conclude();
  end
endmodule
